// ---- fpk_pkg.sv ----
// Function
// [RULE1] config register: only key-access bit 5 lives
// [RULE2] key-access bit writable only when key enabled
// [RULE3] key-access 0: array write starts command sequence
// [RULE4] key-access 1: array writes are backdoor keys
// [RULE5] array reads always served
// [RULE6] protection write accepted only if size grows
// [RULE7] protection loaded from nonvolatile byte at reset
// [RULE8] program/erase in protected range flags violation
// [RULE9] mass erase refused while anything protected
// [RULE10] open bit 0 protects whole array
// [RULE11] open bit 1: size code selects range
// [RULE12] codes 0x00-0x3E: array 0 plus array 1 top
// [RULE13] codes 0x3F-0x7F: array 0 top only
// [RULE14] compare sizes of stored and written values
// [RULE15] range check on array-relative offset
// [RULE16] key enable field enabled only for pattern 10
// [RULE17] violation cleared by writing 1; blocks commands
package fpk_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [11:0] FPK_OFF_CONFIG = 12'h000; // flash_config
  localparam logic [11:0] FPK_OFF_PROT = 12'h004; // flash_protection
  localparam logic [11:0] FPK_OFF_STATUS = 12'h008; // flash_status subset
  localparam logic [11:0] FPK_OFF_OPTIONS = 12'h00C; // flash_options subset

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FPK_KEY_ACCESS_ENABLE_BIT = 5; // key_access_enable
  localparam int FPK_VIOL_BIT = 5; // protection_violation_flag
  localparam int FPK_OPEN_BIT = 0; // protect_open
  localparam int FPK_SIZE_LSB = 1; // protect_size_code low bit
  localparam int FPK_BACKDOOR_KEY_ENABLE_FIELD_LSB = 6; // backdoor_key_enable_field

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [1:0] FPK_BACKDOOR_KEY_ENABLE_FIELD_ON = 2'h2; // only enabled pattern
  localparam logic [6:0] FPK_CODE_A1_LAST = 7'h3E; // last code touching array 1
  localparam logic [6:0] FPK_CODE_A0_BASE = 7'h3F; // first code array 0 only
  localparam logic [6:0] FPK_CODE_NONE = 7'h7F; // nothing protected
  localparam logic [7:0] FPK_SIZE_FULL = 8'h80; // 128 KB, open bit clear
  localparam logic [7:0] FPK_SIZE_TOP = 8'h7F; // size = this minus code
  localparam int FPK_ADDR_W = 17; // two 64 KB arrays

  // reset values; protection starts full until the byte is loaded
  localparam logic [7:0] FPK_CONFIG_RST = 8'h00;
  localparam logic [7:0] FPK_PROT_RST = 8'h00;
  localparam logic [1:0] FPK_BACKDOOR_KEY_ENABLE_FIELD_RST = 2'h0;

  // command kinds presented by the command sequencer
  localparam logic [1:0] FPK_CMD_PROGRAM = 2'h0;
  localparam logic [1:0] FPK_CMD_SECTOR = 2'h1;
  localparam logic [1:0] FPK_CMD_MASS = 2'h2;
  localparam logic [1:0] FPK_CMD_VERIFY = 2'h3;

  // boot sequence after reset release
  typedef enum logic [1:0] {
    BOOT_SYNC1,
    BOOT_SYNC2,
    BOOT_LOAD,
    BOOT_RUN
  } fpk_boot_t;

endpackage

// ---- fpk_range.sv ----
`timescale 1ns/1ns
// -----------------------------------------------------------------
// protected range decoder for one protection byte
// -----------------------------------------------------------------
module fpk_range import fpk_pkg::*; #(
  parameter int ADDR_W = FPK_ADDR_W
) (
  input wire logic [7:0] prot_value,
  input wire logic [ADDR_W-1:0] addr,
  output logic addr_protected,
  output logic any_protected,
  output logic [7:0] size_kb
);

  // the decode leans on bit 16 as array select
  if (ADDR_W != FPK_ADDR_W) begin : g_bad_width
    $error("fpk_range: ADDR_W must be 17");
  end

  logic open_bit; // protect_open
  logic [6:0] code; // protect_size_code
  logic [6:0] kb_idx; // 1 KB sector index inside one array
  logic in_a1; // address falls in array 1

  assign open_bit = prot_value[FPK_OPEN_BIT];
  assign code = prot_value[7:FPK_SIZE_LSB];
  assign kb_idx = {1'b0, addr[15:10]}; // [RULE15]
  assign in_a1 = addr[16]; // [RULE15]

  // ---------------------------------------------------------------
  // size and hit decode
  // ---------------------------------------------------------------
  always_comb begin
    // both halves of the table reduce to 127 minus the code
    size_kb = open_bit ? (FPK_SIZE_TOP - {1'b0, code}) : FPK_SIZE_FULL; // [RULE14]
    any_protected = !open_bit || (code != FPK_CODE_NONE);
    if (!open_bit) begin
      addr_protected = 1'b1; // [RULE10]
    end else if (code <= FPK_CODE_A1_LAST) begin
      // all of array 0, array 1 from (code+1) KB up
      addr_protected = !in_a1 || (kb_idx > code); // [RULE11] [RULE12]
    end else begin
      // array 1 open, array 0 from (code-0x3F) KB up
      addr_protected = !in_a1 && (kb_idx >= (code - FPK_CODE_A0_BASE)); // [RULE13]
    end
  end

endmodule

// ---- fpk_gate.sv ----
`timescale 1ns/1ns
// -----------------------------------------------------------------
// flash protection and backdoor key gate, APB slave
// -----------------------------------------------------------------
module fpk_gate import fpk_pkg::*; #(
  parameter int ADDR_W = FPK_ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] nv_protection_byte,
  input wire logic [7:0] nv_options_byte,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic cmd_seq_start,
  output logic key_wr,
  output logic [ADDR_W-1:0] key_addr,
  output logic [7:0] key_data,
  output logic rd_ack,
  input wire logic cmd_req,
  input wire logic [1:0] cmd_kind,
  input wire logic [ADDR_W-1:0] cmd_addr,
  output logic cmd_go,
  output logic cmd_refused,
  output logic prot_violation
);

  if (ADDR_W != FPK_ADDR_W) begin : g_bad_width
    $error("fpk_gate: ADDR_W must be 17");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fpk_boot_t boot, next_boot; // load sequence after reset
  logic [7:0] nvp_s1, nvp_s2, next_nvp_s1, next_nvp_s2; // nv byte sync
  logic [1:0] key_s1, key_s2, next_key_s1, next_key_s2; // key field sync
  logic key_access_enable, next_key_access_enable;
  logic [7:0] flash_protection, next_flash_protection;
  logic [1:0] backdoor_key_enable_field, next_backdoor_key_enable_field;
  logic next_prot_violation;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_cmd_seq_start, next_key_wr, next_rd_ack;
  logic [ADDR_W-1:0] next_key_addr;
  logic [7:0] next_key_data;
  logic next_cmd_go, next_cmd_refused;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  logic running; // boot load finished
  logic key_enabled; // field decodes to enabled
  logic hit; // mapped register address
  logic wr_fire; // edge at which a write lands
  logic cur_hit, cur_any; // command target vs stored range
  logic [7:0] cur_size, new_size; // stored and written sizes
  logic alters; // command is a program or sector erase

  assign running = (boot == BOOT_RUN);
  assign key_enabled = (backdoor_key_enable_field == FPK_BACKDOOR_KEY_ENABLE_FIELD_ON); // [RULE16]
  assign hit = (paddr == FPK_OFF_CONFIG) || (paddr == FPK_OFF_PROT)
    || (paddr == FPK_OFF_STATUS) || (paddr == FPK_OFF_OPTIONS);
  assign wr_fire = psel && penable && pready && pwrite;
  assign alters = (cmd_kind == FPK_CMD_PROGRAM) || (cmd_kind == FPK_CMD_SECTOR);

  // stored value against the command address
  fpk_range #(.ADDR_W(ADDR_W)) u_cur (
    .prot_value(flash_protection),
    .addr(cmd_addr),
    .addr_protected(cur_hit),
    .any_protected(cur_any),
    .size_kb(cur_size)
  );

  // written value, only its size matters
  fpk_range #(.ADDR_W(ADDR_W)) u_new (
    .prot_value(pwdata[7:0]),
    .addr(cmd_addr),
    .addr_protected(),
    .any_protected(),
    .size_kb(new_size)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    // defaults: hold state, pulses low
    next_boot = boot;
    next_nvp_s1 = nv_protection_byte;
    next_nvp_s2 = nvp_s1;
    next_key_s1 = nv_options_byte[7:FPK_BACKDOOR_KEY_ENABLE_FIELD_LSB];
    next_key_s2 = key_s1;
    next_key_access_enable = key_access_enable;
    next_flash_protection = flash_protection;
    next_backdoor_key_enable_field = backdoor_key_enable_field;
    next_prot_violation = prot_violation;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_cmd_seq_start = 1'b0;
    next_key_wr = 1'b0;
    next_key_addr = key_addr;
    next_key_data = key_data;
    next_rd_ack = 1'b0;
    next_cmd_go = 1'b0;
    next_cmd_refused = 1'b0;

    // boot: wait for both sync stages, then latch nv bytes
    case (boot)
      BOOT_SYNC1: begin
        next_boot = BOOT_SYNC2;
      end
      BOOT_SYNC2: begin
        next_boot = BOOT_LOAD;
      end
      BOOT_LOAD: begin
        next_flash_protection = nvp_s2; // [RULE7]
        next_backdoor_key_enable_field = key_s2; // [RULE16]
        next_boot = BOOT_RUN;
      end
      BOOT_RUN: begin
        next_boot = BOOT_RUN;
      end
      default: begin
        next_boot = BOOT_SYNC1;
      end
    endcase

    // apb: one wait state, held off until boot load is done
    if (psel && penable && !pready && running) begin
      next_pready = 1'b1;
      next_pslverr = !hit;
      case (paddr)
        FPK_OFF_CONFIG: begin
          next_prdata = 32'h0000_0000;
          next_prdata[FPK_KEY_ACCESS_ENABLE_BIT] = key_access_enable; // [RULE1]
        end
        FPK_OFF_PROT: begin
          next_prdata = {24'h00_0000, flash_protection};
        end
        FPK_OFF_STATUS: begin
          next_prdata = 32'h0000_0000;
          next_prdata[FPK_VIOL_BIT] = prot_violation;
        end
        FPK_OFF_OPTIONS: begin
          next_prdata = 32'h0000_0000;
          next_prdata[FPK_BACKDOOR_KEY_ENABLE_FIELD_LSB+1:FPK_BACKDOOR_KEY_ENABLE_FIELD_LSB] = backdoor_key_enable_field;
        end
        default: begin
          next_prdata = 32'h0000_0000;
        end
      endcase
    end

    // register writes land on the completing edge
    if (wr_fire) begin
      case (paddr)
        FPK_OFF_CONFIG: begin
          // other bits have no storage at all
          if (key_enabled) begin
            next_key_access_enable = pwdata[FPK_KEY_ACCESS_ENABLE_BIT]; // [RULE1] [RULE2]
          end
        end
        FPK_OFF_PROT: begin
          // shrinking or equal writes are dropped whole
          if (new_size > cur_size) begin
            next_flash_protection = pwdata[7:0]; // [RULE6] [RULE14]
          end
        end
        FPK_OFF_STATUS: begin
          if (pwdata[FPK_VIOL_BIT]) begin
            next_prot_violation = 1'b0; // [RULE17]
          end
        end
        default: begin
          next_prot_violation = next_prot_violation;
        end
      endcase
    end

    // cpu writes into the array change meaning with key access
    if (running && cpu_wr) begin
      if (key_access_enable) begin
        next_key_wr = 1'b1; // [RULE4]
        next_key_addr = cpu_addr;
        next_key_data = cpu_wdata;
      end else if (!prot_violation) begin
        next_cmd_seq_start = 1'b1; // [RULE3] [RULE17]
      end
    end

    // reads pass untouched in either mode
    if (running && cpu_rd) begin
      next_rd_ack = 1'b1; // [RULE5]
    end

    // command screening; a new violation beats a same-cycle clear
    if (running && cmd_req) begin
      if (prot_violation) begin
        next_cmd_refused = 1'b1; // [RULE17]
        next_prot_violation = 1'b1;
      end else if (cmd_kind == FPK_CMD_MASS && cur_any) begin
        next_cmd_refused = 1'b1; // [RULE9]
        next_prot_violation = 1'b1;
      end else if (alters && cur_hit) begin
        next_cmd_refused = 1'b1; // [RULE8] [RULE15]
        next_prot_violation = 1'b1;
      end else begin
        next_cmd_go = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // registers; async reset loads constants only
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot <= BOOT_SYNC1;
      nvp_s1 <= FPK_PROT_RST;
      nvp_s2 <= FPK_PROT_RST;
      key_s1 <= FPK_BACKDOOR_KEY_ENABLE_FIELD_RST;
      key_s2 <= FPK_BACKDOOR_KEY_ENABLE_FIELD_RST;
      key_access_enable <= FPK_CONFIG_RST[FPK_KEY_ACCESS_ENABLE_BIT];
      flash_protection <= FPK_PROT_RST;
      backdoor_key_enable_field <= FPK_BACKDOOR_KEY_ENABLE_FIELD_RST;
      prot_violation <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      cmd_seq_start <= 1'b0;
      key_wr <= 1'b0;
      key_addr <= '0;
      key_data <= 8'h00;
      rd_ack <= 1'b0;
      cmd_go <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      boot <= next_boot;
      nvp_s1 <= next_nvp_s1;
      nvp_s2 <= next_nvp_s2;
      key_s1 <= next_key_s1;
      key_s2 <= next_key_s2;
      key_access_enable <= next_key_access_enable;
      flash_protection <= next_flash_protection;
      backdoor_key_enable_field <= next_backdoor_key_enable_field;
      prot_violation <= next_prot_violation;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      cmd_seq_start <= next_cmd_seq_start;
      key_wr <= next_key_wr;
      key_addr <= next_key_addr;
      key_data <= next_key_data;
      rd_ack <= next_rd_ack;
      cmd_go <= next_cmd_go;
      cmd_refused <= next_cmd_refused;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cfg_read_bits: assert property ( // [RULE1]
    pready && !pwrite && paddr == FPK_OFF_CONFIG |-> (prdata & 32'hFFFF_FFDF) == 32'h0
  ) else $error("config read shows bits other than key access");

  a_key_write_gated: assert property ( // [RULE2]
    wr_fire && paddr == FPK_OFF_CONFIG && !key_enabled |=> $stable(key_access_enable)
  ) else $error("key access changed while key field disabled");

  a_cmd_start_path: assert property ( // [RULE3]
    running && cpu_wr && !key_access_enable && !prot_violation |=> cmd_seq_start && !key_wr
  ) else $error("array write did not start a command sequence");

  a_key_path: assert property ( // [RULE4]
    running && cpu_wr && key_access_enable |=> key_wr && !cmd_seq_start
      && key_data == $past(cpu_wdata)
  ) else $error("array write not taken as backdoor key");

  a_read_pass: assert property ( // [RULE5]
    running && cpu_rd |=> rd_ack
  ) else $error("array read not served");

  a_prot_no_shrink: assert property ( // [RULE6]
    wr_fire && paddr == FPK_OFF_PROT && new_size <= cur_size |=> $stable(flash_protection)
  ) else $error("protection write shrank or kept size yet landed");

  a_boot_load: assert property ( // [RULE7]
    boot == BOOT_LOAD |=> flash_protection == $past(nvp_s2) && running
  ) else $error("protection not loaded from nonvolatile byte");

  a_viol_set: assert property ( // [RULE8]
    running && cmd_req && alters && cur_hit |=> prot_violation && cmd_refused && !cmd_go
  ) else $error("protected program or erase not refused");

  a_mass_refuse: assert property ( // [RULE9]
    running && cmd_req && cmd_kind == FPK_CMD_MASS && cur_any |=> !cmd_go ##1 !cmd_go
  ) else $error("mass erase allowed while protected");

  a_closed_all: assert property ( // [RULE10]
    running && cmd_req && alters && !flash_protection[FPK_OPEN_BIT] |=> cmd_refused
  ) else $error("closed protection let a command through");

  a_viol_blocks: assert property ( // [RULE17]
    prot_violation && running && (cmd_req || cpu_wr) |=> !cmd_go && !cmd_seq_start
  ) else $error("command went ahead while violation set");

endmodule

// ---- fpk_gate_tb.sv ----
`timescale 1ns/1ns
module testbench import fpk_pkg::*;;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic pclk = 1'b0; // bus clock, 100 MHz
  logic presetn = 1'b0; // async reset, active low
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] nv_protection_byte = 8'hFF; // image loaded at reset
  logic [7:0] nv_options_byte = 8'h00; // key field in bits 7:6
  logic cpu_wr = 1'b0;
  logic cpu_rd = 1'b0;
  logic [FPK_ADDR_W-1:0] cpu_addr = '0;
  logic [7:0] cpu_wdata = 8'h00;
  logic cmd_seq_start;
  logic key_wr;
  logic [FPK_ADDR_W-1:0] key_addr;
  logic [7:0] key_data;
  logic rd_ack;
  logic cmd_req = 1'b0;
  logic [1:0] cmd_kind = 2'h0;
  logic [FPK_ADDR_W-1:0] cmd_addr = '0;
  logic cmd_go;
  logic cmd_refused;
  logic prot_violation;
  int errors = 0; // mismatches
  int cmp_count = 0; // comparisons made
  logic [31:0] rd_val; // last read data
  logic rd_err; // last slave error

  // one row: protection write, readback, then a screened command
  typedef struct packed {
    logic [7:0] wval;
    logic [7:0] exp_prot;
    logic [1:0] kind;
    logic [16:0] addr;
    logic exp_ref;
  } fpk_row_t;

  // rows run in order; sizes only ever grow, so order matters
  fpk_row_t rows [12] = '{
    '{8'hFF, 8'hFF, FPK_CMD_MASS, 17'h00000, 1'b0},
    '{8'hFD, 8'hFD, FPK_CMD_PROGRAM, 17'h0FC00, 1'b1},
    '{8'hFF, 8'hFD, FPK_CMD_PROGRAM, 17'h0FBFF, 1'b0},
    '{8'hFD, 8'hFD, FPK_CMD_MASS, 17'h00000, 1'b1},
    '{8'h7F, 8'h7F, FPK_CMD_SECTOR, 17'h00000, 1'b1},
    '{8'h81, 8'h7F, FPK_CMD_PROGRAM, 17'h10000, 1'b0},
    '{8'h7D, 8'h7D, FPK_CMD_PROGRAM, 17'h1FC00, 1'b1},
    '{8'h7B, 8'h7B, FPK_CMD_SECTOR, 17'h1F7FF, 1'b0},
    '{8'h01, 8'h01, FPK_CMD_PROGRAM, 17'h103FF, 1'b0},
    '{8'h03, 8'h01, FPK_CMD_PROGRAM, 17'h10400, 1'b1},
    '{8'h00, 8'h00, FPK_CMD_VERIFY, 17'h10000, 1'b0},
    '{8'hFF, 8'h00, FPK_CMD_PROGRAM, 17'h10000, 1'b1}
  };

  // ---------------------------------------------------------------
  // design and clock
  // ---------------------------------------------------------------
  fpk_gate #(.ADDR_W(FPK_ADDR_W)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .nv_protection_byte(nv_protection_byte), .nv_options_byte(nv_options_byte),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cmd_seq_start(cmd_seq_start), .key_wr(key_wr), .key_addr(key_addr),
    .key_data(key_data), .rd_ack(rd_ack), .cmd_req(cmd_req), .cmd_kind(cmd_kind),
    .cmd_addr(cmd_addr), .cmd_go(cmd_go), .cmd_refused(cmd_refused),
    .prot_violation(prot_violation)
  );

  // free-running bus clock
  always begin
    #5 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // compare and count; case inequality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    // one wait state: pready is seen at the second access-phase edge
    check(n, 32'h2);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // cpu access; outputs are sampled at the edge after the pulse
  task automatic cpu_op(input logic wr, input logic rd, input logic [16:0] a,
                        input logic [7:0] d);
    cpu_wr <= wr;
    cpu_rd <= rd;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge pclk);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    @(posedge pclk);
  endtask

  // command screen request, same sampling as cpu_op
  task automatic cmd_op(input logic [1:0] k, input logic [16:0] a);
    cmd_req <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    @(posedge pclk);
    cmd_req <= 1'b0;
    @(posedge pclk);
  endtask

  // reset with chosen nonvolatile images; held 6 cycles
  task automatic do_reset(input logic [7:0] prot, input logic [7:0] opt);
    nv_protection_byte <= prot;
    nv_options_byte <= opt;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    // sync and load take three edges; start on the fourth
    repeat (4) @(posedge pclk);
  endtask

  // the single place where the run ends
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog: the whole run needs well under 2000 cycles
  // ---------------------------------------------------------------
  initial begin
    #50000;
    errors++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    // patterns 11, 00, 01, 10; enabled one last so key access stays on
    for (int i = 0; i < 4; i++) begin
      do_reset(8'hFF, {2'(i + 3), 6'h00});
      apb(1'b1, FPK_OFF_OPTIONS, 32'h0);
      apb(1'b0, FPK_OFF_OPTIONS, 32'h0);
      check(rd_val & 32'hC0, {24'h0, 2'(i + 3), 6'h00});
      apb(1'b0, FPK_OFF_PROT, 32'h0);
      check(rd_val, 32'hFF);
      apb(1'b1, FPK_OFF_CONFIG, 32'hFF);
      apb(1'b0, FPK_OFF_CONFIG, 32'h0);
      check(rd_val, (i == 3) ? 32'h20 : 32'h00);
    end
    $display("test key_field done");
    // key access on: writes become keys, reads still served
    cpu_op(1'b1, 1'b0, 17'h1ABCD, 8'h5A);
    check({31'h0, key_wr}, 32'h1);
    check({31'h0, cmd_seq_start}, 32'h0);
    check({15'h0, key_addr}, 32'h1ABCD);
    check({24'h0, key_data}, 32'h5A);
    cpu_op(1'b0, 1'b1, 17'h00010, 8'h00);
    check({31'h0, rd_ack}, 32'h1);
    // key access off: writes start command sequences
    apb(1'b1, FPK_OFF_CONFIG, 32'h0);
    cpu_op(1'b1, 1'b0, 17'h00400, 8'hA5);
    check({30'h0, cmd_seq_start, key_wr}, 32'h2);
    $display("test key_access done");
    // unmapped word answers with an error and zero data
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    check(rd_val, 32'h0);
    $display("test unmapped done");
    // protection growth and range screening table
    foreach (rows[r]) begin
      apb(1'b1, FPK_OFF_PROT, {24'h0, rows[r].wval});
      apb(1'b0, FPK_OFF_PROT, 32'h0);
      check(rd_val, {24'h0, rows[r].exp_prot});
      cmd_op(rows[r].kind, rows[r].addr);
      check({30'h0, cmd_go, cmd_refused}, {30'h0, ~rows[r].exp_ref, rows[r].exp_ref});
      if (rows[r].exp_ref) begin
        check({31'h0, prot_violation}, 32'h1);
        apb(1'b1, FPK_OFF_STATUS, 32'h20);
      end
    end
    $display("test protection_table done");
    // a set violation blocks commands and sequence starts
    cmd_op(FPK_CMD_PROGRAM, 17'h00000);
    check({31'h0, prot_violation}, 32'h1);
    cmd_op(FPK_CMD_VERIFY, 17'h00000);
    check({30'h0, cmd_go, cmd_refused}, 32'h1);
    cpu_op(1'b1, 1'b0, 17'h00000, 8'h11);
    check({30'h0, cmd_seq_start, key_wr}, 32'h0);
    // writing zero leaves the flag, writing one clears it
    apb(1'b1, FPK_OFF_STATUS, 32'h00);
    apb(1'b0, FPK_OFF_STATUS, 32'h0);
    check(rd_val & 32'h20, 32'h20);
    apb(1'b1, FPK_OFF_STATUS, 32'h20);
    apb(1'b0, FPK_OFF_STATUS, 32'h0);
    check(rd_val & 32'h20, 32'h00);
    cmd_op(FPK_CMD_VERIFY, 17'h00000);
    check({30'h0, cmd_go, cmd_refused}, 32'h2);
    $display("test violation done");
    // raise key access and the flag so the reset has something to clear
    apb(1'b1, FPK_OFF_CONFIG, 32'h20);
    cmd_op(FPK_CMD_PROGRAM, 17'h00000);
    check({31'h0, prot_violation}, 32'h1);
    // mid-run reset reloads the new byte and drops key access
    do_reset(8'h7F, 8'h80);
    apb(1'b0, FPK_OFF_PROT, 32'h0);
    check(rd_val, 32'h7F);
    apb(1'b0, FPK_OFF_CONFIG, 32'h0);
    check(rd_val, 32'h00);
    check({31'h0, rd_err}, 32'h0);
    check({31'h0, prot_violation}, 32'h0);
    $display("test reload done");
    tally_and_finish();
  end
endmodule
